// ==== rtl/asq_defines.svh ====
// offsets, field positions, reset values and timing counts of the step sequencer
`ifndef ASQ_DEFINES_SVH
`define ASQ_DEFINES_SVH

// ----------------------------------------------------------------------
// time base
// ----------------------------------------------------------------------
`define ASQ_CLK_HZ        25000000
`define ASQ_PULSE_MS      100
`define ASQ_UNIT_MS       100
`define ASQ_QUNIT_MS      10
`define ASQ_PULSE_CYC     (`ASQ_PULSE_MS * (`ASQ_CLK_HZ / 1000))
`define ASQ_UNIT_CYC      (`ASQ_UNIT_MS * (`ASQ_CLK_HZ / 1000))
`define ASQ_QUNIT_CYC     (`ASQ_QUNIT_MS * (`ASQ_CLK_HZ / 1000))

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define ASQ_OFF_CTRL      8'h00
`define ASQ_OFF_QUAL      8'h04
`define ASQ_OFF_STEPS     8'h08
`define ASQ_OFF_INFN_LO   8'h0C
`define ASQ_OFF_INFN_HI   8'h10
`define ASQ_OFF_OUTFN     8'h14
`define ASQ_OFF_STATUS    8'h18
`define ASQ_OFF_IRQ_STAT  8'h1C
`define ASQ_OFF_IRQ_MASK  8'h20
`define ASQ_OFF_TBL_BASE  8'h40
`define ASQ_OFF_TBL_LAST  8'hBF

// ----------------------------------------------------------------------
// fields and codes
// ----------------------------------------------------------------------
`define ASQ_CTRL_AUTO_BIT 4
`define ASQ_APP_AUTO_SEQ  3'h4
`define ASQ_FN_SEQ1       8'h29
`define ASQ_FN_SEQ2       8'h2A
`define ASQ_FN_MANUAL     8'h2B
`define ASQ_FN_GO_STEP    8'h2C
`define ASQ_FN_HOLD_STEP  8'h2D
`define ASQ_FN_STEP_PULSE 8'h14
`define ASQ_FN_SEQ_PULSE  8'h15
`define ASQ_IRQ_STEP_BIT  0
`define ASQ_IRQ_LAST_BIT  1

// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define ASQ_QUAL_DEF      8'h0A
`define ASQ_QUAL_MIN      8'h02
`define ASQ_QUAL_MAX      8'hC8
`define ASQ_STEPS_DEF     4'h2
`define ASQ_STEPS_MIN     4'h1
`define ASQ_STEPS_MAX     4'h8
`define ASQ_TIME_DEF      13'h0032
`define ASQ_TIME_MIN      13'h0001
`define ASQ_TIME_MAX      13'h1770
`define ASQ_FREQ_DEF      16'h044C

`endif

// ==== rtl/asq_pkg.sv ====
// types shared by the step sequencer
package asq_pkg;

  // one-hot sequencer states
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_LOAD   = 5'h02,
    ST_RAMP   = 5'h04,
    ST_STEADY = 5'h08,
    ST_WAIT   = 5'h10
  } asq_state_type;

  // timing word of one step, 0.1 s units
  typedef struct packed {
    logic        fwd;
    logic [1:0]  pad_hi;
    logic [12:0] steady;
    logic [2:0]  pad_lo;
    logic [12:0] ramp;
  } asq_timing_type;

  // command handed to the motor control core
  typedef struct packed {
    logic        run;
    logic        fwd;
    logic        manual;
    logic [15:0] freq;
  } asq_drive_type;

endpackage

// ==== rtl/asq_top.sv ====
// automatic step sequencer with avalon-mm register slave
//
// Added by the designer: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "asq_defines.svh"

// Contract
// [RULE1] sequencer and step table live only in mode 4
// [RULE2] two independent sequences stored and runnable
// [RULE3] codes 41 and 42 start sequence one, two
// [RULE4] code 43 hands drive back to normal sources
// [RULE5] code 44 advances step, auto-B, motor stopped
// [RULE6] input qualification delay 0.02 to 2.00 s
// [RULE7] per-sequence step count 1 to 8, default 2
// [RULE8] every step has frequency, ramp, steady, direction
// [RULE9] hold step frequency for steady time
// [RULE10] relay code 20 pulses 100 ms per step
// [RULE11] output code 21 pulses 100 ms at last step
// [RULE12] auto-A runs all steps without further inputs
// [RULE13] hold input in auto-A keeps current step
// [RULE14] ramp to step frequency over ramp time
// [RULE15] controller holds start input past qualification
module asq_top #(
  parameter int N_IN      = 8,
  parameter int PULSE_CYC = `ASQ_PULSE_CYC,
  parameter int UNIT_CYC  = `ASQ_UNIT_CYC,
  parameter int QUNIT_CYC = `ASQ_QUNIT_CYC
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  wire logic [7:0]          address_i,
  input  wire logic                read_i,
  input  wire logic                write_i,
  input  wire logic [31:0]         writedata_i,
  input  wire logic [3:0]          byteenable_i,
  output logic      [31:0]         readdata_o,
  output logic                     waitrequest_o,
  input  wire logic [N_IN-1:0]     term_i,
  output asq_pkg::asq_drive_type   drive_o,
  output logic      [1:0]          relay_o,
  output logic                     q1_o,
  output logic                     irq_o
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [2:0]              app_mode;
  logic                    auto_b;
  logic [7:0]              qual;
  logic [3:0]              step_cnt [2];
  logic [7:0]              in_fn [8];
  logic [7:0]              out_fn [3];
  logic [1:0]              irq_stat;
  logic [1:0]              irq_mask;
  logic [15:0]             freq_mem [16];
  asq_pkg::asq_timing_type tim_mem [16];
  logic                    enabled;
  logic                    bus_wr;
  logic [31:0]             wmask;
  logic [7:0]              tbl_off;
  logic                    tbl_hit;
  logic [31:0]             next_rdata;
  logic [31:0]             cur_word;
  logic [31:0]             merged;
  logic [31:0]             qtick_cnt;
  logic [31:0]             tick_cnt;
  logic                    qtick;
  logic                    tick;
  logic [N_IN-1:0]         term_q;
  logic [7:0]              qcnt [N_IN];
  logic                    seq1_lvl, seq2_lvl, manual_lvl, go_lvl, hold_lvl;
  logic                    seq1_d, seq2_d, go_d;
  asq_pkg::asq_state_type  state;
  logic                    seq_sel;
  logic [2:0]              step_idx;
  logic [12:0]             steady_left;
  logic [15:0]             target;
  logic [15:0]             delta;
  logic [47:0]             ramp_acc;
  logic [47:0]             ramp_div;
  logic [47:0]             acc_sum;
  logic                    step_evt;
  logic                    last_evt;
  logic [31:0]             step_pcnt;
  logic [31:0]             seq_pcnt;
  logic [3:0]              ent_idx;
  logic [15:0]             ent_freq;
  asq_pkg::asq_timing_type ent_tim;
  logic                    is_last;
  logic                    sel_lvl;

  assign enabled = (app_mode == `ASQ_APP_AUTO_SEQ); // RULE1
  assign bus_wr  = write_i && !waitrequest_o;
  assign wmask   = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                    {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};
  assign tbl_off = address_i - `ASQ_OFF_TBL_BASE;
  assign tbl_hit = enabled && (address_i >= `ASQ_OFF_TBL_BASE) &&
                   (address_i <= `ASQ_OFF_TBL_LAST); // RULE1

  // ----------------------------------------------------------------------
  // avalon slave: one wait cycle, then completion
  // ----------------------------------------------------------------------
  // readback mux; unmapped addresses read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (address_i == `ASQ_OFF_CTRL) begin
      next_rdata = {27'h0, auto_b, 1'b0, app_mode};
    end else if (address_i == `ASQ_OFF_QUAL) begin
      next_rdata = {24'h0, qual};
    end else if (address_i == `ASQ_OFF_STEPS) begin
      next_rdata = {24'h0, step_cnt[1], step_cnt[0]};
    end else if (address_i == `ASQ_OFF_INFN_LO) begin
      next_rdata = {in_fn[3], in_fn[2], in_fn[1], in_fn[0]};
    end else if (address_i == `ASQ_OFF_INFN_HI) begin
      next_rdata = {in_fn[7], in_fn[6], in_fn[5], in_fn[4]};
    end else if (address_i == `ASQ_OFF_OUTFN) begin
      next_rdata = {8'h0, out_fn[2], out_fn[1], out_fn[0]};
    end else if (address_i == `ASQ_OFF_STATUS) begin
      next_rdata = {drive_o.freq, 3'h0, state, step_idx, seq_sel,
                    enabled, drive_o.manual, drive_o.fwd, drive_o.run};
    end else if (address_i == `ASQ_OFF_IRQ_STAT) begin
      next_rdata = {30'h0, irq_stat};
    end else if (address_i == `ASQ_OFF_IRQ_MASK) begin
      next_rdata = {30'h0, irq_mask};
    end else if (tbl_hit && !tbl_off[2]) begin
      next_rdata = {16'h0, freq_mem[tbl_off[6:3]]};
    end else if (tbl_hit) begin
      next_rdata = tim_mem[tbl_off[6:3]];
    end
  end

  // handshake: waitrequest drops for exactly one cycle per request
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      waitrequest_o <= 1'b1;
      readdata_o    <= 32'h0000_0000;
    end else if (ce_i) begin
      if ((read_i || write_i) && waitrequest_o) begin
        waitrequest_o <= 1'b0;
        readdata_o    <= next_rdata;
      end else begin
        waitrequest_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  assign cur_word = next_rdata;
  assign merged   = (cur_word & ~wmask) | (writedata_i & wmask);

  // out-of-range settings are clamped, never rejected
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      app_mode    <= 3'h0;
      auto_b      <= 1'b0;
      qual        <= `ASQ_QUAL_DEF;
      step_cnt[0] <= `ASQ_STEPS_DEF;
      step_cnt[1] <= `ASQ_STEPS_DEF;
      for (int i = 0; i < 8; i++) in_fn[i] <= 8'h00;
      for (int i = 0; i < 3; i++) out_fn[i] <= 8'h00;
      irq_mask    <= 2'h0;
    end else if (ce_i && bus_wr) begin
      if (address_i == `ASQ_OFF_CTRL) begin
        app_mode <= merged[2:0];
        auto_b   <= merged[`ASQ_CTRL_AUTO_BIT];
      end else if (address_i == `ASQ_OFF_QUAL) begin
        if (merged[7:0] < `ASQ_QUAL_MIN) qual <= `ASQ_QUAL_MIN; // RULE6
        else if (merged[7:0] > `ASQ_QUAL_MAX) qual <= `ASQ_QUAL_MAX;
        else qual <= merged[7:0];
      end else if (address_i == `ASQ_OFF_STEPS) begin
        for (int s = 0; s < 2; s++) begin
          if (merged[4*s +: 4] < `ASQ_STEPS_MIN) begin
            step_cnt[s] <= `ASQ_STEPS_MIN; // RULE7
          end else if (merged[4*s +: 4] > `ASQ_STEPS_MAX) begin
            step_cnt[s] <= `ASQ_STEPS_MAX;
          end else begin
            step_cnt[s] <= merged[4*s +: 4];
          end
        end
      end else if (address_i == `ASQ_OFF_INFN_LO) begin
        for (int i = 0; i < 4; i++) in_fn[i] <= merged[8*i +: 8];
      end else if (address_i == `ASQ_OFF_INFN_HI) begin
        for (int i = 0; i < 4; i++) in_fn[i+4] <= merged[8*i +: 8];
      end else if (address_i == `ASQ_OFF_OUTFN) begin
        for (int i = 0; i < 3; i++) out_fn[i] <= merged[8*i +: 8];
      end else if (address_i == `ASQ_OFF_IRQ_MASK) begin
        irq_mask <= merged[1:0];
      end
    end
  end

  // step table: two sequences of eight steps, writable only in mode 4
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        freq_mem[i]       <= `ASQ_FREQ_DEF;
        tim_mem[i]        <= '0;
        tim_mem[i].fwd    <= 1'b1;
        tim_mem[i].steady <= `ASQ_TIME_DEF;
        tim_mem[i].ramp   <= `ASQ_TIME_DEF;
      end
    end else if (ce_i && bus_wr && tbl_hit) begin
      if (!tbl_off[2]) begin
        freq_mem[tbl_off[6:3]] <= merged[15:0]; // RULE8
      end else begin
        tim_mem[tbl_off[6:3]].fwd <= merged[31];
        if (merged[28:16] < `ASQ_TIME_MIN) begin
          tim_mem[tbl_off[6:3]].steady <= `ASQ_TIME_MIN;
        end else if (merged[28:16] > `ASQ_TIME_MAX) begin
          tim_mem[tbl_off[6:3]].steady <= `ASQ_TIME_MAX;
        end else begin
          tim_mem[tbl_off[6:3]].steady <= merged[28:16];
        end
        if (merged[12:0] < `ASQ_TIME_MIN) begin
          tim_mem[tbl_off[6:3]].ramp <= `ASQ_TIME_MIN;
        end else if (merged[12:0] > `ASQ_TIME_MAX) begin
          tim_mem[tbl_off[6:3]].ramp <= `ASQ_TIME_MAX;
        end else begin
          tim_mem[tbl_off[6:3]].ramp <= merged[12:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // time base: 10 ms qualification tick, 100 ms step tick
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      qtick_cnt <= 32'h0;
      tick_cnt  <= 32'h0;
      qtick     <= 1'b0;
      tick      <= 1'b0;
    end else if (ce_i) begin
      qtick     <= (qtick_cnt == 32'(QUNIT_CYC - 1));
      tick      <= (tick_cnt == 32'(UNIT_CYC - 1));
      qtick_cnt <= (qtick_cnt == 32'(QUNIT_CYC - 1)) ? 32'h0 : qtick_cnt + 1;
      tick_cnt  <= (tick_cnt == 32'(UNIT_CYC - 1)) ? 32'h0 : tick_cnt + 1;
    end
  end

  // ----------------------------------------------------------------------
  // terminal qualification and function decode
  // ----------------------------------------------------------------------
  // a terminal level is accepted only after it has differed for qual ticks
  for (genvar k = 0; k < N_IN; k++) begin : g_qual
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        qcnt[k]   <= 8'h00;
        term_q[k] <= 1'b0;
      end else if (ce_i && qtick) begin
        if (term_i[k] == term_q[k]) begin
          qcnt[k] <= 8'h00;
        end else if (qcnt[k] + 8'h01 >= qual) begin
          qcnt[k]   <= 8'h00;
          term_q[k] <= term_i[k]; // RULE6 RULE15
        end else begin
          qcnt[k] <= qcnt[k] + 8'h01;
        end
      end
    end
  end

  // several terminals may share a function; any one active counts
  always_comb begin
    seq1_lvl   = 1'b0;
    seq2_lvl   = 1'b0;
    manual_lvl = 1'b0;
    go_lvl     = 1'b0;
    hold_lvl   = 1'b0;
    for (int k = 0; k < N_IN; k++) begin
      seq1_lvl   |= term_q[k] && (in_fn[k] == `ASQ_FN_SEQ1); // RULE3
      seq2_lvl   |= term_q[k] && (in_fn[k] == `ASQ_FN_SEQ2); // RULE3
      manual_lvl |= term_q[k] && (in_fn[k] == `ASQ_FN_MANUAL);
      go_lvl     |= term_q[k] && (in_fn[k] == `ASQ_FN_GO_STEP);
      hold_lvl   |= term_q[k] && (in_fn[k] == `ASQ_FN_HOLD_STEP);
    end
  end

  // edge memory for start and advance inputs
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seq1_d <= 1'b0;
      seq2_d <= 1'b0;
      go_d   <= 1'b0;
    end else if (ce_i) begin
      seq1_d <= seq1_lvl;
      seq2_d <= seq2_lvl;
      go_d   <= go_lvl;
    end
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  assign ent_idx  = {seq_sel, step_idx}; // RULE2
  assign ent_freq = freq_mem[ent_idx];
  assign ent_tim  = tim_mem[ent_idx];
  assign is_last  = ({1'b0, step_idx} + 4'h1 >= step_cnt[seq_sel]); // RULE7
  assign sel_lvl  = seq_sel ? seq2_lvl : seq1_lvl;
  assign acc_sum  = ramp_acc + {32'h0, delta};

  // ramp uses a rate accumulator: one 0.01 Hz unit per overflow, so
  // no divider is needed; at most one unit moves per clock
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state       <= asq_pkg::ST_IDLE;
      seq_sel     <= 1'b0;
      step_idx    <= 3'h0;
      steady_left <= 13'h0;
      target      <= 16'h0;
      delta       <= 16'h0;
      ramp_acc    <= 48'h0;
      ramp_div    <= 48'h1;
      step_evt    <= 1'b0;
      last_evt    <= 1'b0;
      drive_o     <= '0;
    end else if (ce_i) begin
      step_evt       <= 1'b0;
      last_evt       <= 1'b0;
      drive_o.manual <= manual_lvl || !enabled; // RULE4
      if (!enabled || manual_lvl ||
          (auto_b && !sel_lvl && state != asq_pkg::ST_IDLE)) begin
        state        <= asq_pkg::ST_IDLE; // RULE1 RULE4
        drive_o.run  <= 1'b0;
        drive_o.freq <= 16'h0;
      end else begin
        case (state)
          asq_pkg::ST_IDLE: begin
            if ((seq1_lvl && !seq1_d) || (seq2_lvl && !seq2_d)) begin
              seq_sel  <= !(seq1_lvl && !seq1_d); // RULE3
              step_idx <= 3'h0;
              state    <= asq_pkg::ST_LOAD;
            end
          end
          asq_pkg::ST_LOAD: begin
            target      <= ent_freq; // RULE14
            drive_o.fwd <= ent_tim.fwd;
            drive_o.run <= 1'b1;
            delta       <= (ent_freq > drive_o.freq) ?
                           ent_freq - drive_o.freq : drive_o.freq - ent_freq;
            ramp_div    <= 48'(ent_tim.ramp) * 48'(UNIT_CYC); // RULE14
            ramp_acc    <= 48'h0;
            step_evt    <= 1'b1; // RULE10
            last_evt    <= is_last; // RULE11
            state       <= asq_pkg::ST_RAMP;
          end
          asq_pkg::ST_RAMP: begin
            if (drive_o.freq == target) begin
              steady_left <= ent_tim.steady;
              state       <= asq_pkg::ST_STEADY;
            end else if (acc_sum >= ramp_div) begin
              ramp_acc <= acc_sum - ramp_div;
              if (target > drive_o.freq) drive_o.freq <= drive_o.freq + 16'h1;
              else drive_o.freq <= drive_o.freq - 16'h1; // RULE14
            end else begin
              ramp_acc <= acc_sum;
            end
          end
          asq_pkg::ST_STEADY: begin
            if (tick && !(hold_lvl && !auto_b)) begin // RULE13
              if (steady_left > 13'h1) begin
                steady_left <= steady_left - 13'h1; // RULE9
              end else if (is_last) begin
                state        <= asq_pkg::ST_IDLE;
                drive_o.run  <= 1'b0;
                drive_o.freq <= 16'h0;
              end else if (!auto_b) begin
                step_idx <= step_idx + 3'h1; // RULE12
                state    <= asq_pkg::ST_LOAD;
              end else begin
                drive_o.run  <= 1'b0;
                drive_o.freq <= 16'h0;
                state        <= asq_pkg::ST_WAIT;
              end
            end
          end
          asq_pkg::ST_WAIT: begin
            if (go_lvl && !go_d && !drive_o.run) begin
              step_idx <= step_idx + 3'h1; // RULE5
              state    <= asq_pkg::ST_LOAD;
            end
          end
          default: state <= asq_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // step and sequence pulses, relay and output terminals
  // ----------------------------------------------------------------------
  // a new step event restarts the pulse rather than stretching it
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_pcnt <= 32'h0;
      seq_pcnt  <= 32'h0;
      relay_o   <= 2'h0;
      q1_o      <= 1'b0;
    end else if (ce_i) begin
      if (step_evt) step_pcnt <= 32'(PULSE_CYC);
      else if (step_pcnt != 32'h0) step_pcnt <= step_pcnt - 1;
      if (last_evt) seq_pcnt <= 32'(PULSE_CYC);
      else if (seq_pcnt != 32'h0) seq_pcnt <= seq_pcnt - 1;
      for (int r = 0; r < 2; r++) begin
        relay_o[r] <= (out_fn[r] == `ASQ_FN_STEP_PULSE) &&
                      (step_pcnt != 32'h0); // RULE10
      end
      q1_o <= (out_fn[2] == `ASQ_FN_SEQ_PULSE) &&
              (seq_pcnt != 32'h0); // RULE11
    end
  end

  // ----------------------------------------------------------------------
  // interrupts: sticky, write one to clear, set wins
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat <= 2'h0;
      irq_o    <= 1'b0;
    end else if (ce_i) begin
      for (int b = 0; b < 2; b++) begin
        if ((b == `ASQ_IRQ_STEP_BIT && step_evt) ||
            (b == `ASQ_IRQ_LAST_BIT && last_evt)) begin
          irq_stat[b] <= 1'b1;
        end else if (bus_wr && address_i == `ASQ_OFF_IRQ_STAT &&
                     byteenable_i[0] && writedata_i[b]) begin
          irq_stat[b] <= 1'b0;
        end
      end
      irq_o <= |(irq_stat & irq_mask);
    end
  end

endmodule
`default_nettype wire

// ==== bench/asq_term_model.sv ====
// switch bank model that drives the input terminals of the sequencer
`timescale 1ns/1ps
`default_nettype none
module asq_term_model #(
  parameter int N_IN = 8
) (
  input  wire logic            clk_i,
  input  wire logic [N_IN-1:0] cmd_i,
  output var  logic [N_IN-1:0] term_o
);
  // contacts change one clock after the command, then stay as long as held
  always_ff @(posedge clk_i) term_o <= cmd_i;
endmodule
`default_nettype wire

// ==== bench/asq_top_asserts.sv ====
// port assertions for the step sequencer top
`timescale 1ns/1ps
`default_nettype none
module asq_top_asserts #(
  parameter int N_IN      = 8,
  parameter int PULSE_CYC = 20
) (
  input wire logic                   core_clk_i,
  input wire logic                   rst_i,
  input wire logic                   ce_i,
  input wire logic [7:0]             address_i,
  input wire logic                   read_i,
  input wire logic                   write_i,
  input wire logic [31:0]            writedata_i,
  input wire logic [3:0]             byteenable_i,
  input wire logic [31:0]            readdata_o,
  input wire logic                   waitrequest_o,
  input wire logic [N_IN-1:0]        term_i,
  input wire asq_pkg::asq_drive_type drive_o,
  input wire logic [1:0]             relay_o,
  input wire logic                   q1_o,
  input wire logic                   irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  int q1_cnt;
  // length of the running sequence-end pulse
  always_ff @(posedge core_clk_i or posedge rst_i)
    if (rst_i) q1_cnt <= 0;
    else q1_cnt <= q1_o ? q1_cnt + 1 : 0;
  wait_one_a: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("wait low longer than one cycle");
  wait_answer_a: assert property ((read_i || write_i) && ce_i &&
    waitrequest_o |=> !waitrequest_o) else $error("request not answered");
  wait_cause_a: assert property (!waitrequest_o |-> $past(read_i || write_i))
    else $error("answer without request");
  unmapped_zero_a: assert property (read_i && !waitrequest_o &&
    address_i == 8'h30 |-> readdata_o == 32'h0) else $error("unmapped read");
  q1_len_a: assert property ($fell(q1_o) |-> q1_cnt == PULSE_CYC)
    else $error("end pulse length wrong");
  step_pulse_a: assert property (
    $rose(relay_o[0]) |-> relay_o[0][*8])
    else $error("step pulse too short");
  manual_idle_a: assert property (
    drive_o.manual && $past(drive_o.manual) |->
    !drive_o.run && drive_o.freq == 16'h0) else $error("manual still runs");
  ramp_slope_a: assert property (
    drive_o.run && $past(drive_o.run) |->
    16'(drive_o.freq - $past(drive_o.freq) + 16'h1) <= 16'h2)
    else $error("frequency jumped");
endmodule
bind asq_top asq_top_asserts #(.N_IN(N_IN), .PULSE_CYC(PULSE_CYC)) u_chk (
  .core_clk_i, .rst_i, .ce_i, .address_i, .read_i, .write_i, .writedata_i,
  .byteenable_i, .readdata_o, .waitrequest_o, .term_i, .drive_o, .relay_o,
  .q1_o, .irq_o);
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the step sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                   clk = 0;
  logic                   rst = 1;
  logic [7:0]             address = 8'h00;
  logic                   rd = 0;
  logic                   wr = 0;
  logic [31:0]            wdata = 32'h0;
  logic [31:0]            rdata;
  logic                   wreq;
  logic [7:0]             cmd = 8'h00;
  logic [7:0]             term;
  asq_pkg::asq_drive_type drv;
  logic [1:0]             relay;
  logic                   q1;
  logic                   irq;
  logic                   r_p = 0;
  logic                   q_p = 0;
  logic                   ce = 1;
  logic [3:0]             be = 4'hF;
  int                     err_count = 0;
  int                     tests_run = 0;
  int                     steps_seen = 0;
  int                     ends_seen = 0;
  always #20 clk = ~clk;
  // count pulse starts
  always @(posedge clk) begin
    if (relay[0] && !r_p) steps_seen++;
    if (q1 && !q_p) ends_seen++;
    r_p <= relay[0];
    q_p <= q1;
  end
  asq_term_model #(.N_IN(8)) u_sw (.clk_i(clk), .cmd_i(cmd), .term_o(term));
  asq_top #(.N_IN(8), .PULSE_CYC(20), .UNIT_CYC(10), .QUNIT_CYC(5)) dut (
    .core_clk_i(clk), .rst_i(rst), .ce_i(ce), .address_i(address),
    .read_i(rd), .write_i(wr), .writedata_i(wdata), .byteenable_i(be),
    .readdata_o(rdata), .waitrequest_o(wreq), .term_i(term), .drive_o(drv),
    .relay_o(relay), .q1_o(q1), .irq_o(irq));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one bus cycle, held until waitrequest low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    address <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    do begin @(posedge clk); n++; end while (wreq !== 1'b0 && n < 40);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 40) begin err_count++; wrap_up(); end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, string n);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, e, q);
  endtask
  function automatic bit cnd(input int k);
    case (k)
      0: return drv.run === 1'b1;
      1: return drv.run === 1'b0;
      2: return drv.freq === 16'h0005;
      default: return drv.freq === 16'h0003;
    endcase
  endfunction
  // bounded wait for a drive condition
  task automatic wait_on(input int k);
    int n;
    n = 0;
    while (!cnd(k) && n < 4000) begin @(posedge clk); n++; end
    if (n >= 4000) begin
      err_count++;
      $display("[FAIL] wait %0d expected 1 seen 0", k);
      wrap_up();
    end
  endtask
  task automatic t_regs();
    rreg(8'h04, 32'h0A, "qual");
    rreg(8'h08, 32'h22, "steps");
    rreg(8'h30, 32'h0, "unmapped");
    wreg(8'h00, 32'h4);
    rreg(8'h40, 32'h44C, "freq0");
    rreg(8'h44, 32'h80320032, "time0");
    wreg(8'h00, 32'h1);
    rreg(8'h40, 32'h0, "locked");
    chk("manual", 1, drv.manual);
    wreg(8'h04, 32'h0);
    be <= 4'hE;
    wreg(8'h04, 32'h50);
    rreg(8'h04, 32'h2, "qual_min");
    be <= 4'hF;
    $display("test regs done");
  endtask
  task automatic t_auto_a();
    int n;
    wreg(8'h00, 32'h4);
    wreg(8'h08, 32'h12);
    wreg(8'h0C, 32'h2C2B2A29);
    wreg(8'h10, 32'h2D);
    wreg(8'h14, 32'h00150014);
    wreg(8'h20, 32'h3);
    wreg(8'h40, 32'h5);
    wreg(8'h44, 32'h80030001);
    wreg(8'h48, 32'h3);
    wreg(8'h4C, 32'h00030001);
    steps_seen = 0;
    ends_seen = 0;
    cmd <= 8'h01;
    wait_on(2);
    chk("fwd", 1, drv.fwd);
    n = 0;
    while (drv.freq === 16'h5 && n < 100) begin @(posedge clk); n++; end
    chk("steady", 1, n >= 20 && n <= 45);
    wait_on(3);
    chk("rev", 0, drv.fwd);
    cmd <= 8'h00;
    wait_on(1);
    chk("steps", 2, steps_seen);
    chk("ends", 1, ends_seen);
    chk("irq", 1, irq);
    rreg(8'h1C, 32'h3, "irq_stat");
    wreg(8'h20, 32'h0);
    repeat (3) @(posedge clk);
    chk("irq_mask", 0, irq);
    wreg(8'h1C, 32'h3);
    rreg(8'h1C, 32'h0, "irq_clr");
    $display("test auto_a done");
  endtask
  task automatic t_auto_b();
    wreg(8'h00, 32'h14);
    steps_seen = 0;
    cmd <= 8'h01;
    wait_on(0);
    wait_on(1);
    repeat (60) @(posedge clk);
    chk("b_wait", 0, drv.run);
    ce <= 1'b0;
    cmd <= 8'h09;
    repeat (60) @(posedge clk);
    chk("ce_hold", 0, drv.run);
    ce <= 1'b1;
    wait_on(0);
    repeat (5) @(posedge clk);
    chk("b_steps", 2, steps_seen);
    cmd <= 8'h00;
    wait_on(1);
    $display("test auto_b done");
  endtask
  task automatic t_manual();
    wreg(8'h00, 32'h4);
    cmd <= 8'h02;
    wait_on(0);
    cmd <= 8'h06;
    wait_on(1);
    chk("manual", 1, drv.manual);
    cmd <= 8'h00;
    $display("test manual done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_auto_a();
    t_auto_b();
    t_manual();
    wrap_up();
  end
endmodule
`default_nettype wire
